// *** hw/sma_mem_engine.sv ***
// Memory engine: connection memory, codes and tristate field
module sma_mem_engine (
   input wire logic clk_sys,
   input wire logic reset_n,
   sma_mem_if.eng mi
);
   import sma_pkg::*;
   logic [7:0] cm_data_mem [256];
   logic [3:0] cm_code_mem [256];
   logic [7:0] ts_mem [256];
   sma_eng_e state_q, state_d;
   logic [7:0] idx_q, idx_d, wd_q, wd_d;
   logic [3:0] code_q, code_d;
   logic ts_q, ts_d, den_q, den_d, cen_q, cen_d, we;

   // Next operation; a fill walks every location once
   always_comb begin
      state_d = state_q;
      idx_d = idx_q;
      wd_d = wd_q;
      code_d = code_q;
      ts_d = ts_q;
      den_d = den_q;
      cen_d = cen_q;
      case (state_q)
         SMA_IDLE: begin
            if (mi.start) begin
               wd_d = mi.wdata;
               code_d = mi.cmd[3:0];
               ts_d = (mi.cmd[7:4] == SMA_CMD_TS);
               if (ts_d) begin
                  den_d = 1'b1;
                  cen_d = 1'b0;
                  state_d = mi.cmd[SMA_CMD_ALL] ? SMA_FILL : SMA_ONE;
               end else if (mi.cm_reset_mode) begin
                  den_d = 1'b1;
                  cen_d = 1'b0;
                  state_d = SMA_FILL;
               end else begin
                  den_d = sma_writes_data(mi.cmd[3:0]);
                  cen_d = 1'b1;
                  state_d = SMA_ONE;
               end
               idx_d = (state_d == SMA_FILL) ? 8'h00 : mi.addr;
            end
         end
         SMA_ONE: state_d = SMA_IDLE;
         SMA_FILL: begin
            idx_d = idx_q + 8'h01;
            if (idx_q == SMA_MEM_LAST) begin
               state_d = SMA_IDLE;
            end
         end
         default: state_d = SMA_IDLE;
      endcase
   end

   // Engine registers
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= SMA_IDLE;
         idx_q <= 8'h00;
         wd_q <= 8'h00;
         code_q <= 4'h0;
         ts_q <= 1'b0;
         den_q <= 1'b0;
         cen_q <= 1'b0;
      end else begin
         state_q <= state_d;
         idx_q <= idx_d;
         wd_q <= wd_d;
         code_q <= code_d;
         ts_q <= ts_d;
         den_q <= den_d;
         cen_q <= cen_d;
      end
   end

   // Memory writes; busy falls on the edge of the last write
   assign we = (state_q != SMA_IDLE);
   always_ff @(posedge clk_sys) begin
      if (we && ts_q) begin
         ts_mem[idx_q] <= wd_q;
      end
      if (we && !ts_q && den_q) begin
         cm_data_mem[idx_q] <= wd_q;
      end
      if (we && !ts_q && cen_q) begin
         cm_code_mem[idx_q] <= code_q;
      end
   end

   // Status and read port
   assign mi.busy = we;
   assign mi.done = (state_q == SMA_ONE) || (state_q == SMA_FILL && idx_q == SMA_MEM_LAST);
   assign mi.rd_data = cm_data_mem[mi.rd_addr];
   assign mi.rd_code = cm_code_mem[mi.rd_addr];
   assign mi.rd_ts = ts_mem[mi.rd_addr];

   // ==========================
   // Checks
   code_store_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      state_q == SMA_ONE && cen_q |=> cm_code_mem[$past(idx_q)] == $past(code_q))
      else $error("code not stored");
   ts_store_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      we && ts_q |=> ts_mem[$past(idx_q)] == $past(wd_q))
      else $error("tristate not stored");
endmodule

// *** hw/sma_mem_if.sv ***
// Carrier between register front end and memory engine
interface sma_mem_if;
   logic start;
   logic [7:0] cmd;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic cm_reset_mode;
   logic busy;
   logic done;
   logic [7:0] rd_addr;
   logic [7:0] rd_data;
   logic [3:0] rd_code;
   logic [7:0] rd_ts;
   modport eng (input start, cmd, addr, wdata, cm_reset_mode, rd_addr,
                output busy, done, rd_data, rd_code, rd_ts);
   modport ctl (output start, cmd, addr, wdata, cm_reset_mode, rd_addr,
                input busy, done, rd_data, rd_code, rd_ts);
endinterface

// *** hw/sma_pkg.sv ***
// Constants and helpers for the switch memory access block
package sma_pkg;
   // ==========================
   // Register word indices (byte address = 4 x index)
   localparam logic [5:0] SMA_IDX_CMD = 6'h00;
   localparam logic [5:0] SMA_IDX_ADDR = 6'h01;
   localparam logic [5:0] SMA_IDX_DATA = 6'h02;
   localparam logic [5:0] SMA_IDX_STATUS = 6'h0D;
   localparam logic [5:0] SMA_IDX_INT = 6'h0E;
   localparam logic [5:0] SMA_IDX_MASK = 6'h20;
   localparam logic [5:0] SMA_IDX_MODE = 6'h21;
   // ==========================
   // Field positions and reset values
   localparam logic [7:0] SMA_STATUS_BASE = 8'h05;
   localparam int SMA_ST_BUSY = 3;
   localparam int SMA_ST_SYNC = 5;
   localparam int SMA_INT_DONE = 0;
   localparam int SMA_INT_PFI = 3;
   localparam int SMA_OMS_LSB = 6;
   localparam logic [1:0] SMA_OMS_CMRESET = 2'b00;
   localparam logic [1:0] SMA_OMS_NORMAL = 2'b11;
   localparam logic [7:0] SMA_MODE_RST = 8'h00;
   localparam logic [7:0] SMA_MASK_RST = 8'h00;
   localparam logic [7:0] SMA_MEM_LAST = 8'hFF;
   localparam int SMA_CI_LSB = 2;
   // ==========================
   // Command encodings
   localparam logic [3:0] SMA_CMD_CM = 4'h7;
   localparam logic [3:0] SMA_CMD_TS = 4'h6;
   localparam int SMA_CMD_ALL = 3;
   localparam logic [3:0] SMA_CODE_ODD_DEC = 4'h0;
   localparam logic [3:0] SMA_CODE_ODD_HDLC = 4'hB;

   typedef enum logic [1:0] {SMA_IDLE, SMA_ONE, SMA_FILL} sma_eng_e;

   // Odd-slot codes store the code only
   function automatic logic sma_writes_data(input logic [3:0] code);
      return !(code == SMA_CODE_ODD_DEC || code == SMA_CODE_ODD_HDLC);
   endfunction

   // Command byte is a known memory operation
   function automatic logic sma_cmd_ok(input logic [7:0] c);
      return c[7:4] == SMA_CMD_CM || (c[7:4] == SMA_CMD_TS && c[2:0] == 3'h0);
   endfunction

   // Signalling code fields held in a data byte
   function automatic logic [3:0] sma_ci_tx(input logic [7:0] d);
      return d[SMA_CI_LSB+:4];
   endfunction
   function automatic logic [4:0] sma_ci_ref(input logic [7:0] d);
      return d[SMA_CI_LSB+:5];
   endfunction
endpackage

// *** hw/sma_sync2.sv ***
// Two-stage synchroniser for a level from a pin
module sma_sync2 (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic din,
   output logic dout
);
   logic meta_q;
   // First stage feeds only the second
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         meta_q <= 1'b0;
         dout <= 1'b0;
      end else begin
         meta_q <= din;
         dout <= meta_q;
      end
   end
endmodule

// *** hw/sma_top.sv ***
// Switch memory access block with APB registers and interrupt
//
// Contract
// - Command 71h writes the data byte and code 0001 at the address.
// - Command 78h writes the data byte and code 1000 at the address.
// - Command 70h writes only code 0000 and keeps the stored data.
// - Command 7Ah writes data and code 1010; 7Bh writes only code 1011.
// - Busy stays set until the access ends; host waits for it to read 0.
// - The stored byte of an upstream slot is the 5-bit signalling reference.
// - The stored byte of a downstream slot gives the 4-bit code to send.
// - Writing C0h to the mode register enters normal mode and, with sync present, raises the irq.
// - In normal mode a sync change sets the framing interrupt (08h); synced status is 25h.
// - Command 68h copies the data byte into the whole tristate field.
// - Command 60h writes one tristate position chosen by the address.
// - Writing 80h leaves reset mode for init mode; codes follow only then.
//
// The address map and the APB register port were decided locally.
module sma_top (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   input wire logic pcm_sync_pin,
   input wire logic [7:0] slot_sel,
   input wire logic [4:0] ci_rx,
   output logic [7:0] slot_cm_data,
   output logic [3:0] slot_cm_code,
   output logic [7:0] slot_ts_ctrl,
   output logic [3:0] ci_tx,
   output logic ci_match
);
   import sma_pkg::*;

   sma_mem_if mi ();
   logic sync_s;
   logic [7:0] cmd_q, cmd_d, addr_q, addr_d, data_q, data_d;
   logic [7:0] ist_q, ist_d, mask_q, mask_d, mode_q, mode_d;
   logic sync_prev_q, irq_d, pready_d, pslverr_d;
   logic [31:0] prdata_d;
   logic [5:0] idx;
   logic acc, wr_fire, rd_prep, hit, start;
   logic [7:0] wb, status, pfi_set, done_set;
   logic to_normal;

   // ==========================
   // Submodules
   sma_sync2 u_sync (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .din(pcm_sync_pin),
      .dout(sync_s)
   );

   sma_mem_engine u_eng (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .mi(mi)
   );

   // ==========================
   // APB decode
   assign idx = paddr[7:2];
   assign acc = psel && penable;
   assign wr_fire = acc && pready && pwrite && !pslverr;
   assign rd_prep = acc && !pready;
   assign wb = pwdata[7:0];
   assign hit = (paddr[1:0] == 2'b00) && (idx == SMA_IDX_CMD || idx == SMA_IDX_ADDR
      || idx == SMA_IDX_DATA || idx == SMA_IDX_STATUS || idx == SMA_IDX_INT
      || idx == SMA_IDX_MASK || idx == SMA_IDX_MODE);

   // Status view: fixed ready bits, sync state and busy
   always_comb begin
      status = SMA_STATUS_BASE;
      status[SMA_ST_SYNC] = sync_s;
      status[SMA_ST_BUSY] = mi.busy;
   end

   // Answer one cycle into the access phase; errors for holes and busy commands
   always_comb begin
      pready_d = rd_prep;
      pslverr_d = 1'b0;
      prdata_d = prdata;
      if (rd_prep) begin
         pslverr_d = !hit || (pwrite && idx == SMA_IDX_CMD && mi.busy);
         prdata_d = 32'h0000_0000;
         case (idx)
            SMA_IDX_CMD: prdata_d[7:0] = cmd_q;
            SMA_IDX_ADDR: prdata_d[7:0] = addr_q;
            SMA_IDX_DATA: prdata_d[7:0] = data_q;
            SMA_IDX_STATUS: prdata_d[7:0] = status;
            SMA_IDX_INT: prdata_d[7:0] = ist_q;
            SMA_IDX_MASK: prdata_d[7:0] = mask_q;
            SMA_IDX_MODE: prdata_d[7:0] = mode_q;
            default: prdata_d = 32'h0000_0000;
         endcase
      end else if (!acc) begin
         pslverr_d = 1'b0;
      end
   end

   // ==========================
   // Register writes
   always_comb begin
      cmd_d = cmd_q;
      addr_d = addr_q;
      data_d = data_q;
      mask_d = mask_q;
      mode_d = mode_q;
      start = 1'b0;
      if (wr_fire) begin
         case (idx)
            SMA_IDX_CMD: begin
               cmd_d = wb;
               start = sma_cmd_ok(wb);
            end
            SMA_IDX_ADDR: addr_d = wb;
            SMA_IDX_DATA: data_d = wb;
            SMA_IDX_MASK: mask_d = wb;
            SMA_IDX_MODE: mode_d = wb;
            default: cmd_d = cmd_q;
         endcase
      end
   end

   // Engine hookup; mode bits 00 mean reset mode, so a connection command fills data only
   assign mi.start = start;
   assign mi.cmd = wb;
   assign mi.addr = addr_q;
   assign mi.wdata = data_q;
   assign mi.cm_reset_mode = (mode_q[SMA_OMS_LSB+:2] == SMA_OMS_CMRESET);
   assign mi.rd_addr = slot_sel;

   // ==========================
   // Interrupts: sticky bits, write one to clear, set wins
   assign to_normal = wr_fire && idx == SMA_IDX_MODE
      && wb[SMA_OMS_LSB+:2] == SMA_OMS_NORMAL
      && mode_q[SMA_OMS_LSB+:2] != SMA_OMS_NORMAL;

   always_comb begin
      pfi_set = 8'h00;
      done_set = 8'h00;
      pfi_set[SMA_INT_PFI] = (mode_q[SMA_OMS_LSB+:2] == SMA_OMS_NORMAL
         && sync_s != sync_prev_q) || (to_normal && sync_s);
      done_set[SMA_INT_DONE] = mi.done;
      ist_d = ist_q;
      if (wr_fire && idx == SMA_IDX_INT) begin
         ist_d = ist_q & ~wb;
      end
      ist_d = ist_d | pfi_set | done_set;
      irq_d = |(ist_q & ~mask_q);
   end

   // Control and status registers
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         cmd_q <= 8'h00;
         addr_q <= 8'h00;
         data_q <= 8'h00;
         mask_q <= SMA_MASK_RST;
         mode_q <= SMA_MODE_RST;
         ist_q <= 8'h00;
         sync_prev_q <= 1'b0;
         irq <= 1'b0;
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         cmd_q <= cmd_d;
         addr_q <= addr_d;
         data_q <= data_d;
         mask_q <= mask_d;
         mode_q <= mode_d;
         ist_q <= ist_d;
         sync_prev_q <= sync_s;
         irq <= irq_d;
         pready <= pready_d;
         pslverr <= pslverr_d;
         prdata <= prdata_d;
      end
   end

   // ==========================
   // Slot lookup for the framing logic; one cycle from slot_sel
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         slot_cm_data <= 8'h00;
         slot_cm_code <= 4'h0;
         slot_ts_ctrl <= 8'h00;
         ci_tx <= 4'h0;
         ci_match <= 1'b0;
      end else begin
         slot_cm_data <= mi.rd_data;
         slot_cm_code <= mi.rd_code;
         slot_ts_ctrl <= mi.rd_ts;
         ci_tx <= sma_ci_tx(mi.rd_data);
         ci_match <= (ci_rx == sma_ci_ref(mi.rd_data));
      end
   end

   // ==========================
   // Checks
   logic [8:0] busy_cnt_q;
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         busy_cnt_q <= 9'h000;
      end else begin
         busy_cnt_q <= mi.busy ? busy_cnt_q + 9'h001 : 9'h000;
      end
   end

   busy_bound_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      busy_cnt_q <= 9'h100)
      else $error("busy held too long");
   busy_set_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      start |=> mi.busy ##0 status[SMA_ST_BUSY])
      else $error("busy not set by command");
   cmd71_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      start && wb == 8'h71 && !mi.cm_reset_mode |=> ##1
      u_eng.cm_code_mem[$past(addr_q, 2)] == 4'h1
      && u_eng.cm_data_mem[$past(addr_q, 2)] == $past(data_q, 2))
      else $error("71h store wrong");
   cmd78_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      start && wb == 8'h78 && !mi.cm_reset_mode |=> u_eng.den_q && u_eng.code_q == 4'h8)
      else $error("78h decode wrong");
   cmd70_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      start && wb == 8'h70 && !mi.cm_reset_mode |=> !u_eng.den_q && u_eng.cen_q)
      else $error("70h must keep data");
   cmd7b_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      start && wb[7:1] == 7'h3D && !mi.cm_reset_mode
      |=> u_eng.den_q == !$past(wb[0]) && u_eng.code_q == $past(wb[3:0]))
      else $error("7Ah/7Bh decode wrong");
   ci_fields_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      reset_n |=> ci_tx === $past(mi.rd_data[5:2])
      && ci_match === ($past(ci_rx) == $past(mi.rd_data[6:2])))
      else $error("signalling field wrong");
   pfi_irq_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      to_normal && sync_s && !mask_q[SMA_INT_PFI] |-> ##2 irq)
      else $error("normal mode irq missing");
   pfi_set_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      mode_q[7:6] == 2'b11 && $changed(sync_s) |=> ist_q[SMA_INT_PFI])
      else $error("framing interrupt lost");
   fill_ts_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      start && wb == 8'h68 |=> u_eng.state_q == SMA_FILL && u_eng.idx_q == 8'h00
      && u_eng.ts_q)
      else $error("68h fill not started");
   reset_mode_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      start && mi.cm_reset_mode && wb[7:4] == 4'h7 |=> !u_eng.cen_q)
      else $error("code written in reset mode");

   // Bus answer, refusal and interrupt level
   pready_pulse_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      pready |=> !pready)
      else $error("pready held too long");
   prdata_upper_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      pready |-> prdata[31:8] == 24'h00_0000)
      else $error("upper read data not zero");
   busy_refuse_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      rd_prep && pwrite && idx == SMA_IDX_CMD && mi.busy |=> pslverr)
      else $error("command while busy not refused");
   status_write_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      rd_prep && pwrite && idx == SMA_IDX_STATUS |=> !pslverr)
      else $error("status write flagged");
   unknown_cmd_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      wr_fire && idx == SMA_IDX_CMD && !sma_cmd_ok(wb) |=> !mi.busy)
      else $error("unknown command started");
   irq_level_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      reset_n |=> irq == $past(|(ist_q & ~mask_q)))
      else $error("irq level wrong");
   set_wins_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      mi.done |=> ist_q[SMA_INT_DONE])
      else $error("done bit lost");
   pfi_only_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      mode_q[SMA_OMS_LSB+:2] != SMA_OMS_NORMAL && !to_normal |=> !$rose(ist_q[SMA_INT_PFI]))
      else $error("framing interrupt outside normal mode");

   // Memory updates and lookup
   done_busy_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      mi.done |=> !mi.busy)
      else $error("busy left after done");
   keep_data_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      u_eng.state_q == SMA_ONE && !u_eng.ts_q && !u_eng.den_q
      |=> u_eng.cm_data_mem[$past(u_eng.idx_q)] === $past(u_eng.cm_data_mem[u_eng.idx_q]))
      else $error("code-only command changed data");
   ts_lookup_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      reset_n |=> slot_ts_ctrl === $past(mi.rd_ts))
      else $error("tristate lookup wrong");
   mode_write_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      wr_fire && idx == SMA_IDX_MODE |=> mode_q == $past(wb))
      else $error("mode write lost");

   // Main scenarios

   fill_cov: cover property (@(posedge clk_sys) disable iff (!reset_n)
      start && wb == 8'h68 ##1 mi.busy [*8]);
   single_cov: cover property (@(posedge clk_sys) disable iff (!reset_n)
      start && wb == 8'h60 ##2 !mi.busy);
   irq_cov: cover property (@(posedge clk_sys) disable iff (!reset_n)
      to_normal ##[1:4] irq);
   refuse_cov: cover property (@(posedge clk_sys) disable iff (!reset_n)
      rd_prep && pwrite && idx == SMA_IDX_CMD && mi.busy);
   sync_loss_cov: cover property (@(posedge clk_sys) disable iff (!reset_n)
      mode_q[SMA_OMS_LSB+:2] == SMA_OMS_NORMAL && $fell(sync_s));
endmodule

// *** testbench/test_sma_top.sv ***
// Self-checking bench for the switch memory access block
module test_sma_top;
   timeunit 1ns;
   timeprecision 1ps;
   import sma_pkg::*;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic irq;
   logic pcm_sync_pin = 1'b0;
   logic [7:0] slot_sel = 8'h00;
   logic [4:0] ci_rx = 5'h00;
   logic [7:0] slot_cm_data;
   logic [3:0] slot_cm_code;
   logic [7:0] slot_ts_ctrl;
   logic [3:0] ci_tx;
   logic ci_match;
   int err_total = 0;
   int checks_done = 0;
   logic [7:0] rd;
   logic er;

   sma_top sma_top_inst (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
      .pcm_sync_pin(pcm_sync_pin), .slot_sel(slot_sel), .ci_rx(ci_rx),
      .slot_cm_data(slot_cm_data), .slot_cm_code(slot_cm_code),
      .slot_ts_ctrl(slot_ts_ctrl), .ci_tx(ci_tx), .ci_match(ci_match));

   // ==========================
   // Clock at 40 MHz
   initial begin
      forever #12.5 clk_sys = ~clk_sys;
   end

   // Verdict and end of run
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Compare one value and count it
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
      end
   endtask

   // ==========================
   // One APB transfer; answer taken at the rising edge that samples pready high
   task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] d,
                      output logic [7:0] r, output logic e, input logic [1:0] lo = 2'b00);
      int n;
      n = 0;
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx, lo};
      pwdata <= {24'h00_0000, d};
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1 && n < 50) begin
         @(posedge clk_sys);
         n++;
      end
      if (n >= 50) begin
         err_total++;
         $display("unexpected at %0t: no pready", $time);
         finish_test();
      end
      r = prdata[7:0];
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr_reg(input logic [5:0] idx, input logic [7:0] d);
      apb(1'b1, idx, d, rd, er);
      chk(er, 1'b0, "write error");
   endtask

   task automatic rd_reg(input logic [5:0] idx, input logic [7:0] exp, input string msg);
      apb(1'b0, idx, 8'h00, rd, er);
      chk({er, rd}, {1'b0, exp}, msg);
   endtask

   // Poll the busy bit until it reads 0, under a bound
   task automatic wait_idle();
      int n;
      n = 0;
      apb(1'b0, SMA_IDX_STATUS, 8'h00, rd, er);
      while (rd[SMA_ST_BUSY] !== 1'b0 && n < 200) begin
         apb(1'b0, SMA_IDX_STATUS, 8'h00, rd, er);
         n++;
      end
      chk(n < 200, 1'b1, "busy never cleared");
   endtask

   // Look one slot up and compare the memory words
   task automatic look(input logic [7:0] a, input logic [7:0] d, input logic [3:0] c);
      @(posedge clk_sys);
      slot_sel <= a;
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      chk(slot_cm_data, d, "stored data");
      chk(slot_cm_code, c, "stored code");
   endtask

   // ==========================
   // Scenarios
   task automatic sc_reset_values();
      wr_reg(SMA_IDX_STATUS, 8'hFF);
      rd_reg(SMA_IDX_STATUS, 8'h05, "status reset");
      rd_reg(SMA_IDX_INT, 8'h00, "int reset");
      rd_reg(SMA_IDX_MASK, 8'h00, "mask reset");
      rd_reg(SMA_IDX_MODE, 8'h00, "mode reset");
      apb(1'b0, 6'h10, 8'h00, rd, er);
      chk({er, rd}, 9'h100, "unmapped read");
      apb(1'b1, SMA_IDX_MASK, 8'h55, rd, er, 2'b10);
      chk(er, 1'b1, "misaligned write");
      rd_reg(SMA_IDX_MASK, 8'h00, "misaligned ignored");
      wr_reg(SMA_IDX_MASK, 8'hAA);
      rd_reg(SMA_IDX_MASK, 8'hAA, "mask rw");
      wr_reg(SMA_IDX_MASK, 8'h00);
      wr_reg(SMA_IDX_CMD, 8'h55);
      rd_reg(SMA_IDX_STATUS, 8'h05, "unknown command idle");
      rd_reg(SMA_IDX_CMD, 8'h55, "command readback");
   endtask

   // Reset-mode fill, busy on the command write, refusal while busy
   task automatic sc_fill_and_busy();
      wr_reg(SMA_IDX_DATA, 8'hFF);
      wr_reg(SMA_IDX_CMD, 8'h70);
      apb(1'b0, SMA_IDX_STATUS, 8'h00, rd, er);
      chk(rd[SMA_ST_BUSY], 1'b1, "busy after command");
      apb(1'b1, SMA_IDX_CMD, 8'h71, rd, er);
      chk(er, 1'b1, "command while busy");
      wait_idle();
      chk(irq, 1'b1, "done raises irq");
      wr_reg(SMA_IDX_MODE, 8'h80);
      rd_reg(SMA_IDX_MODE, 8'h80, "mode init");
   endtask

   // Connection commands and their stored words
   task automatic sc_connections();
      logic [7:0] cm [6] = '{8'h71, 8'h78, 8'h70, 8'h7A, 8'h7B, 8'h71};
      logic [7:0] ad [6] = '{8'h80, 8'h88, 8'h89, 8'h08, 8'h09, 8'h00};
      logic [7:0] dt [6] = '{8'h89, 8'hFF, 8'h11, 8'hF3, 8'h22, 8'h85};
      logic [7:0] ed [6] = '{8'h89, 8'hFF, 8'hFF, 8'hF3, 8'hFF, 8'h85};
      logic [3:0] ec [6] = '{4'h1, 4'h8, 4'h0, 4'hA, 4'hB, 4'h1};
      for (int i = 0; i < 6; i++) begin
         wr_reg(SMA_IDX_DATA, dt[i]);
         wr_reg(SMA_IDX_ADDR, ad[i]);
         wr_reg(SMA_IDX_CMD, cm[i]);
         wait_idle();
      end
      for (int i = 0; i < 6; i++) begin
         look(ad[i], ed[i], ec[i]);
      end
   endtask

   // Signalling code sent and compared
   task automatic sc_signalling();
      look(8'h08, 8'hF3, 4'hA);
      chk(ci_tx, 4'b1100, "blocking code");
      @(posedge clk_sys);
      ci_rx <= 5'b11111;
      look(8'h88, 8'hFF, 4'h8);
      chk(ci_tx, 4'b1111, "idle code");
      chk(ci_match, 1'b1, "reference match");
      @(posedge clk_sys);
      ci_rx <= 5'b11110;
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      chk(ci_match, 1'b0, "reference mismatch");
   endtask

   // Normal mode, framing interrupt, mask and clear
   task automatic sc_normal_mode();
      @(posedge clk_sys);
      pcm_sync_pin <= 1'b1;
      wr_reg(SMA_IDX_INT, 8'hFF);
      rd_reg(SMA_IDX_INT, 8'h00, "int cleared");
      chk(irq, 1'b0, "irq low after clear");
      wr_reg(SMA_IDX_MODE, 8'hC0);
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
      chk(irq, 1'b1, "irq on normal mode");
      rd_reg(SMA_IDX_INT, 8'h08, "framing int");
      rd_reg(SMA_IDX_STATUS, 8'h25, "synced status");
      wr_reg(SMA_IDX_MASK, 8'h08);
      repeat (2) @(posedge clk_sys);
      chk(irq, 1'b0, "masked irq");
      wr_reg(SMA_IDX_INT, 8'h08);
      wr_reg(SMA_IDX_MASK, 8'h00);
      rd_reg(SMA_IDX_INT, 8'h00, "framing cleared");
      pcm_sync_pin <= 1'b0;
      repeat (6) @(posedge clk_sys);
      rd_reg(SMA_IDX_INT, 8'h08, "sync loss int");
      rd_reg(SMA_IDX_STATUS, 8'h05, "sync lost status");
      wr_reg(SMA_IDX_INT, 8'h08);
   endtask

   // Tristate field: whole fill then a single position
   task automatic sc_tristate();
      wr_reg(SMA_IDX_DATA, 8'h00);
      wr_reg(SMA_IDX_CMD, 8'h68);
      wait_idle();
      wr_reg(SMA_IDX_DATA, 8'h0F);
      wr_reg(SMA_IDX_ADDR, 8'h89);
      wr_reg(SMA_IDX_CMD, 8'h60);
      wait_idle();
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_sys);
         slot_sel <= 8'h87 + 8'(i);
         repeat (2) @(posedge clk_sys);
         @(negedge clk_sys);
         chk(slot_ts_ctrl, (i == 2) ? 8'h0F : 8'h00, "tristate word");
      end
   endtask

   // ==========================
   // Main sequence
   initial begin
      repeat (2) @(posedge clk_sys);
      reset_n <= 1'b1;
      sc_reset_values();
      sc_fill_and_busy();
      sc_connections();
      sc_signalling();
      sc_normal_mode();
      sc_tristate();
      finish_test();
   end

   // Overall bound on the run
   initial begin
      repeat (60000) @(posedge clk_sys);
      err_total++;
      $display("unexpected at %0t: run too long", $time);
      finish_test();
   end
endmodule
